// *** common/sew_map.svh ***
/*
  register offsets, field positions, reset values and timing counts of the
  exposure and readout block. assumes a 100 MHz aclk.
*/
`ifndef SEW_MAP_SVH
`define SEW_MAP_SVH
`define SEW_A_CTRL 8'h00
`define SEW_A_EXPO 8'h04
`define SEW_A_FTIME 8'h08
`define SEW_A_WOFS 8'h0c
`define SEW_A_WSIZE 8'h10
`define SEW_A_PDIV 8'h14
`define SEW_A_STAT 8'h18
`define SEW_B_RUN 0
`define SEW_B_TRIG 1
`define SEW_B_PULSE 2
`define SEW_B_FTEN 3
`define SEW_B_ROWSUP 4
`define SEW_B_AVG 5
`define SEW_B_SUB 6
`define SEW_F_H 12:0
`define SEW_F_V 28:16
`define SEW_M_CTRL 32'h0000007f
`define SEW_M_EXPO 32'h00ffffff
`define SEW_M_FTIME 32'h000fffff
`define SEW_M_WIN 32'h1fff1fff
`define SEW_M_PDIV 32'h000000ff
`define SEW_R_CTRL 32'h00000000
`define SEW_R_EXPO 32'h000003e8
`define SEW_R_FTIME 32'h000186a0
`define SEW_R_WOFS 32'h00000000
`define SEW_R_WSIZE 32'h14001400
`define SEW_R_PDIV 32'h00000000
`define SEW_CLK_NS 10
`define SEW_US_NS 1000
`define SEW_US_CYCLES ((`SEW_US_NS + `SEW_CLK_NS - 1) / `SEW_CLK_NS)
`define SEW_EXP_MIN_US 40
`define SEW_ROW_BLANK_US 1
`define SEW_ROW_BLANK_CYC ((`SEW_ROW_BLANK_US * `SEW_US_NS) / `SEW_CLK_NS)
`define SEW_MIN_W 320
`define SEW_MIN_H 2
`define SEW_W_STEP 8
`endif

// *** common/sew_pkg.sv ***
/*
  types of the exposure and readout block: state codes, pixel carrier, mode.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sew_pkg;
  typedef enum logic [1:0] {exp_idle = 2'b00, exp_run = 2'b01, exp_hold = 2'b11} sew_exp_st_t;
  typedef enum logic [1:0] {rd_idle = 2'b00, rd_row = 2'b01, rd_blank = 2'b11, rd_vblank = 2'b10} sew_rd_st_t;
  typedef struct packed {
    logic sof;
    logic eol;
    logic [9:0] data;
  } sew_pix_t;
  typedef struct packed {
    logic run;
    logic trig;
    logic pulse;
    logic ften;
    logic sup;
    logic avg;
    logic sub;
  } sew_mode_t;
endpackage

// *** logic/sew_avg.sv ***
/*
  2x2 pixel averager with a line buffer of pair sums.
  assumes pixels arrive in raster order, columns counted from zero in the window.
*/
module sew_avg import sew_pkg::*; #(
  parameter int MAX_W = 5120
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic in_valid, // pixel strobe
  input wire sew_pix_t in_pix, // pixel and flags
  input wire logic [12:0] in_col, // column within window
  input wire logic in_odd_row, // second row of a pair
  output logic out_valid, // averaged pixel strobe
  output sew_pix_t out_pix // averaged pixel and flags
);
  logic [10:0] pair_mem [MAX_W/2];
  logic [9:0] left;
  logic [11:0] pair_now;
  logic [11:0] sum4;
  logic emit;

  assign pair_now = {2'b00, left} + {2'b00, in_pix.data};
  assign sum4 = pair_now + {1'b0, pair_mem[in_col[12:1]]};
  assign emit = in_valid && in_col[0] && in_odd_row;

  // no reset on data storage: every word is written before it is read
  always_ff @(posedge aclk) begin
    if (in_valid && !in_col[0]) begin
      left <= in_pix.data;
    end
    if (in_valid && in_col[0] && !in_odd_row) begin
      pair_mem[in_col[12:1]] <= pair_now[10:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_pix <= '0;
    end else begin
      out_valid <= emit;
      if (emit) begin
        out_pix <= '{sof: in_pix.sof, eol: in_pix.eol, data: sum4[11:2]};
      end
    end
  end
endmodule

// *** logic/sew_readout.sv ***
/*
  global-shutter exposure timing, window readout, row and frame blanking,
  subsampling and 4:1 averaging, with an AXI4-Lite register slave.
  assumes the sensor array runs on aclk and answers a read one cycle later.
*/
// Overview of operation
// - reset all pixels, expose, transfer to storage, then read the array.
// - internal exposure at least 40 us; upper limit follows the frame period.
// - free-running: next exposure overlaps readout of the current frame.
// - pulse-width exposure lasts as long as the pulse, at least 40 us.
// - triggered: exposure never overlaps readout; long exposure lengthens frame.
// - programmable pixel rate; lower rate lowers output data rate.
// - frame-time control: after readout, vertical blanking until period elapses.
// - frame period programmable in 1 us steps up to about one second.
// - with frame-time control exposure may exceed sensor readout time.
// - suppression off: one microsecond of blanking after every row; here the last row of a frame goes to rd_vblank instead.
// - row overhead suppression is forced off while averaging is on.
// - one capture window, independent horizontal and vertical offset and size.
// - window at least 320 by 2, width a multiple of 8.
// - window width and height at most the full sensor size.
// - window sets output columns and rows; decimation reduces them further.
// - averaging and subsampling never apply together.
// - averaging exists only on monochrome variants.
// - 4:1 averaging sums four neighbours, divides by four, halves both axes.
// - averaging works on full frame or any capture window.
// - subsampling keeps every other pixel and every other line.
`include "sew_map.svh"
module sew_readout import sew_pkg::*; #(
  parameter int SENSOR_W = 5120,
  parameter int SENSOR_H = 5120,
  parameter bit MONO = 1'b1,
  parameter logic [23:0] EXP_MAX_US = 24'd1000000
) (
  input wire logic aclk, // clock, 100 MHz
  input wire logic aresetn, // synchronous reset, low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic trig_pin, // exposure trigger pin, async
  output logic sens_reset_all, // global pixel reset pulse
  output logic sens_transfer, // charge to storage pulse
  output logic sens_rd, // sensor read strobe
  output logic [12:0] sens_row, // sensor row address
  output logic [12:0] sens_col, // sensor column address
  input wire logic [9:0] sens_data, // sensor pixel, cycle after read
  output logic out_valid, // output pixel strobe
  output sew_pix_t out_pix // output pixel and flags
);
  localparam logic [12:0] FULL_W = 13'(SENSOR_W);
  localparam logic [12:0] FULL_H = 13'(SENSOR_H);
  localparam logic [6:0] US_C = 7'(`SEW_US_CYCLES);
  localparam logic [6:0] BLANK_C = 7'(`SEW_ROW_BLANK_CYC);
  localparam logic [23:0] EXP_MIN = 24'(`SEW_EXP_MIN_US);

  logic [31:0] ctrl, expo, ftime, wofs, wsize, pdiv;
  sew_mode_t mode;
  sew_exp_st_t exp_st;
  sew_rd_st_t rd_st;
  logic [12:0] win_w, win_h, h_off, v_off, col, row, step;
  logic [6:0] ucnt, bcnt;
  logic [7:0] pcnt;
  logic us_tick, pix_en, xfer, last_col, last_row, exp_done;
  logic [23:0] exp_us, exp_tgt, exp_lim;
  logic [19:0] frame_us;
  logic [15:0] frames;
  logic trig_m, trig_s, trig_d, trig_rise;
  logic [12:0] i_col, q_col;
  logic i_odd, i_sof, i_eol, q_odd, q_sof, q_eol, rd_q;
  logic a_valid;
  sew_pix_t a_pix;
  logic aw_hold, w_hold, do_wr;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rd_word;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) v[i*8 +: 8] = nw[i*8 +: 8];
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `SEW_A_CTRL || a == `SEW_A_EXPO || a == `SEW_A_FTIME || a == `SEW_A_WOFS ||
           a == `SEW_A_WSIZE || a == `SEW_A_PDIV || a == `SEW_A_STAT;
  endfunction

  function automatic logic [12:0] fit_size(input logic [12:0] req, input logic [12:0] lo,
                                           input logic [12:0] full, input logic align);
    logic [12:0] v;
    v = align ? (req & ~13'(`SEW_W_STEP - 1)) : req;
    if (v < lo) v = lo;
    if (v > full) v = full;
    return v;
  endfunction

  function automatic logic [12:0] fit_ofs(input logic [12:0] req, input logic [12:0] size,
                                          input logic [12:0] full);
    return (req > full - size) ? full - size : req;
  endfunction

  // illegal settings are overridden here, never stored back
  always_comb begin
    mode.run = ctrl[`SEW_B_RUN];
    mode.trig = ctrl[`SEW_B_TRIG];
    mode.pulse = ctrl[`SEW_B_TRIG] && ctrl[`SEW_B_PULSE];
    mode.ften = ctrl[`SEW_B_FTEN];
    mode.avg = MONO && ctrl[`SEW_B_AVG];
    mode.sub = ctrl[`SEW_B_SUB] && !mode.avg;
    mode.sup = ctrl[`SEW_B_ROWSUP] && !mode.avg;
  end

  // one window; size limited to legal range, offset kept inside the array
  assign win_w = fit_size(wsize[`SEW_F_H], 13'(`SEW_MIN_W), FULL_W, 1'b1);
  assign win_h = fit_size(wsize[`SEW_F_V], 13'(`SEW_MIN_H), FULL_H, 1'b0);
  assign h_off = fit_ofs(wofs[`SEW_F_H], win_w, FULL_W);
  assign v_off = fit_ofs(wofs[`SEW_F_V], win_h, FULL_H);
  assign step = mode.sub ? 13'd2 : 13'd1;
  assign last_col = 13'(col + step) >= win_w;
  assign last_row = 13'(row + step) >= win_h;

  // microsecond tick and pixel rate enable
  assign us_tick = ucnt == US_C - 7'd1;
  assign pix_en = pcnt == pdiv[7:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ucnt <= '0;
      pcnt <= '0;
    end else begin
      ucnt <= us_tick ? 7'd0 : ucnt + 7'd1;
      pcnt <= pix_en ? 8'd0 : pcnt + 8'd1;
    end
  end

  // trigger pin synchroniser; edge taken from the second stage on
  assign trig_rise = trig_s && !trig_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_m <= 1'b0;
      trig_s <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      trig_m <= trig_pin;
      trig_s <= trig_m;
      trig_d <= trig_s;
    end
  end

  // exposure target: frame period caps it when frame-time control is on
  always_comb begin
    exp_lim = mode.ften ? {4'h0, ftime[19:0]} : EXP_MAX_US;
    exp_tgt = expo[23:0];
    if (exp_tgt > exp_lim) exp_tgt = exp_lim;
    if (exp_tgt < EXP_MIN) exp_tgt = EXP_MIN;
  end
  // first tick lands early in the first microsecond, so the count must pass the target
  assign exp_done = mode.pulse ? (!trig_s && exp_us > EXP_MIN) : exp_us > exp_tgt;
  // storage holds one frame, so transfer waits for the reader to go idle
  assign xfer = exp_st == exp_hold && rd_st == rd_idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_st <= exp_idle;
      exp_us <= '0;
      sens_reset_all <= 1'b0;
      sens_transfer <= 1'b0;
    end else begin
      sens_reset_all <= 1'b0;
      sens_transfer <= 1'b0;
      unique case (exp_st)
        exp_idle: begin
          // free run restarts at once (overlap); a trigger edge counts only while the reader is idle
          if (mode.run && (!mode.trig || (trig_rise && rd_st == rd_idle))) begin
            exp_st <= exp_run;
            exp_us <= '0;
            sens_reset_all <= 1'b1;
          end
        end
        exp_run: begin
          if (us_tick && exp_us != '1) exp_us <= exp_us + 24'd1;
          if (exp_done) exp_st <= exp_hold;
        end
        exp_hold: begin
          if (xfer) begin
            sens_transfer <= 1'b1;
            exp_st <= exp_idle;
          end
        end
      endcase
    end
  end

  // frame period measured from each transfer, in microseconds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_us <= '0;
    end else if (xfer) begin
      frame_us <= '0;
    end else if (us_tick && frame_us != '1) begin
      frame_us <= frame_us + 20'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st <= rd_idle;
      col <= '0;
      row <= '0;
      bcnt <= '0;
      frames <= '0;
    end else begin
      unique case (rd_st)
        rd_idle: begin
          if (xfer) begin
            rd_st <= rd_row;
            col <= '0;
            row <= '0;
          end
        end
        rd_row: begin
          if (pix_en) begin
            if (last_col) begin
              col <= '0;
              row <= 13'(row + step);
              if (last_row) begin
                rd_st <= rd_vblank;
                frames <= frames + 16'd1;
              end else if (!mode.sup) begin
                rd_st <= rd_blank;
              end
            end else begin
              col <= 13'(col + step);
            end
          end
        end
        rd_blank: begin
          bcnt <= bcnt + 7'd1;
          if (bcnt == BLANK_C - 7'd1) begin
            bcnt <= '0;
            rd_st <= rd_row;
          end
        end
        rd_vblank: begin
          if (!mode.ften || frame_us > ftime[19:0] || &frame_us) rd_st <= rd_idle;
        end
      endcase
    end
  end

  // sensor address issue, then its flags delayed to meet the returned data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sens_rd <= 1'b0;
      sens_row <= '0;
      sens_col <= '0;
      {i_col, i_odd, i_sof, i_eol} <= '0;
      {q_col, q_odd, q_sof, q_eol, rd_q} <= '0;
    end else begin
      sens_rd <= rd_st == rd_row && pix_en;
      if (rd_st == rd_row && pix_en) begin
        sens_row <= 13'(v_off + row);
        sens_col <= 13'(h_off + col);
        i_col <= col;
        i_odd <= row[0];
        i_sof <= mode.avg ? (row == 13'd1 && col == 13'd1) : (row == 13'd0 && col == 13'd0);
        i_eol <= last_col;
      end
      rd_q <= sens_rd;
      {q_col, q_odd, q_sof, q_eol} <= {i_col, i_odd, i_sof, i_eol};
    end
  end

  sew_avg #(.MAX_W(SENSOR_W)) u_avg (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rd_q && mode.avg),
    .in_pix('{sof: q_sof, eol: q_eol, data: sens_data}),
    .in_col(q_col),
    .in_odd_row(q_odd),
    .out_valid(a_valid),
    .out_pix(a_pix)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_pix <= '0;
    end else if (mode.avg) begin
      out_valid <= a_valid;
      out_pix <= a_pix;
    end else begin
      out_valid <= rd_q;
      out_pix <= '{sof: q_sof, eol: q_eol, data: sens_data};
    end
  end

  // AXI4-Lite: address and data taken in either order, answered together
  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign do_wr = aw_hold && w_hold;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr) ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `SEW_R_CTRL;
      expo <= `SEW_R_EXPO;
      ftime <= `SEW_R_FTIME;
      wofs <= `SEW_R_WOFS;
      wsize <= `SEW_R_WSIZE;
      pdiv <= `SEW_R_PDIV;
    end else if (do_wr) begin
      case (aw_addr)
        `SEW_A_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & `SEW_M_CTRL;
        `SEW_A_EXPO: expo <= merge(expo, w_data, w_strb) & `SEW_M_EXPO;
        `SEW_A_FTIME: ftime <= merge(ftime, w_data, w_strb) & `SEW_M_FTIME;
        `SEW_A_WOFS: wofs <= merge(wofs, w_data, w_strb) & `SEW_M_WIN;
        `SEW_A_WSIZE: wsize <= merge(wsize, w_data, w_strb) & `SEW_M_WIN;
        `SEW_A_PDIV: pdiv <= merge(pdiv, w_data, w_strb) & `SEW_M_PDIV;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (araddr)
      `SEW_A_CTRL: rd_word = ctrl;
      `SEW_A_EXPO: rd_word = expo;
      `SEW_A_FTIME: rd_word = ftime;
      `SEW_A_WOFS: rd_word = wofs;
      `SEW_A_WSIZE: rd_word = wsize;
      `SEW_A_PDIV: rd_word = pdiv;
      `SEW_A_STAT: rd_word = {frames, 11'h000, MONO, rd_st, exp_st};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= mapped(araddr) ? 2'b00 : 2'b10;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exp_end;
    exp_st == exp_run ##1 exp_st == exp_hold;
  endsequence
  sequence s_row_blank_end;
    rd_st == rd_blank ##1 rd_st == rd_row;
  endsequence

  a_xfer_order: assert property (sens_transfer |-> $past(exp_st) == exp_hold && rd_st == rd_row)
    else $error("transfer without finished exposure or readout start");
  a_exp_min_len: assert property (s_exp_end |-> $past(exp_us) >= EXP_MIN)
    else $error("exposure shorter than minimum");
  a_trig_no_overlap: assert property (mode.trig && $rose(exp_st == exp_run) |-> $past(rd_st) == rd_idle)
    else $error("triggered exposure overlaps readout");
  a_pix_rate_gate: assert property (sens_rd |-> $past(pix_en) && $past(rd_st) == rd_row)
    else $error("sensor read outside pixel enable");
  a_vblank_period: assert property (rd_st == rd_vblank ##1 rd_st == rd_idle
    |-> !$past(mode.ften) || $past(frame_us) >= $past(ftime[19:0]))
    else $error("frame period cut short");
  a_row_blank_len: assert property (s_row_blank_end |-> $past(bcnt) == BLANK_C - 7'd1)
    else $error("row blanking length wrong");
  a_avg_mode_legal: assert property (mode.avg |-> MONO && !mode.sup && !mode.sub)
    else $error("illegal mode mix with averaging");
  a_win_legal: assert property (win_w >= 13'(`SEW_MIN_W) && win_w[2:0] == 3'd0 && win_w <= FULL_W
    && win_h >= 13'(`SEW_MIN_H) && win_h <= FULL_H)
    else $error("capture window out of range");
  a_avg_output: assert property (a_valid |-> $past(rd_q) && $past(q_col[0]) && $past(q_odd))
    else $error("average emitted off a 2x2 corner");
endmodule

// *** testbench/sew_sensor_model.sv ***
/*
  behavioural sensor array: answers each read strobe with a pixel made
  from row and column. assumes reads arrive on aclk, address beside strobe.
*/
module sew_sensor_model (
  input wire logic aclk, // clock
  input wire logic sens_rd, // read strobe
  input wire logic [12:0] sens_row, // row address
  input wire logic [12:0] sens_col, // column address
  output logic [9:0] sens_data // pixel, cycle after read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sens_data = 10'h155;
  // lines toggle between reads so stale data never looks right
  always @(posedge aclk) begin
    if (sens_rd) begin
      sens_data <= 10'(sens_row * 13'h25 + sens_col * 13'h3);
    end else begin
      sens_data <= ~sens_data;
    end
  end
endmodule

// *** testbench/test_sensor_exposure_window_readout.sv ***
/*
  self-checking bench of the readout block: frame set-ups from a table,
  then reset, unmapped and reserved-bit cases. assumes the sensor model, 100 MHz.
*/
`include "sew_map.svh"
module test_sensor_exposure_window_readout import sew_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [6:0] ctrl; logic [23:0] expo; logic [19:0] ftime;
    logic [31:0] wofs; logic [31:0] wsize; logic [7:0] pdiv;} sew_row_t;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} sew_wr_t;
  logic aclk = 1'b0, aresetn = 1'b0, trig_pin = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sens_reset_all, sens_transfer, sens_rd, out_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] sens_row, sens_col;
  logic [9:0] sens_data;
  sew_pix_t out_pix;
  int errors = 0, n_compared = 0, cyc = 0;
  int t_rst, t_xfer, t_rd, n_rst, n_xfer, expo_m, per_m, gmin, gmax, nexp;
  logic arm = 1'b0, cap = 1'b0, done, reading = 1'b0, ovl, r1bad;
  logic [10:0] q[$];
  sew_row_t rows[8] = '{ // even window offsets only
    '{7'h01, 24'h28, 20'h3c, 32'h0, 32'h00010145, 8'h00},
    '{7'h01, 24'h05, 20'h3c, 32'h00020008, 32'h00020140, 8'h01},
    '{7'h11, 24'h28, 20'h3c, 32'h0, 32'h00020140, 8'h00},
    '{7'h71, 24'h28, 20'h3c, 32'h00020010, 32'h00040140, 8'h00},
    '{7'h41, 24'h28, 20'h3c, 32'h0, 32'h00040140, 8'h00},
    '{7'h09, 24'h28, 20'h3c, 32'h0, 32'h00020140, 8'h00},
    '{7'h03, 24'h28, 20'h3c, 32'h0, 32'h00020140, 8'h00},
    '{7'h07, 24'h3c, 20'h3c, 32'h0, 32'h00020140, 8'h00}};
  logic [31:0] rv[6] = '{`SEW_R_CTRL, `SEW_R_EXPO, `SEW_R_FTIME, `SEW_R_WOFS, `SEW_R_WSIZE, `SEW_R_PDIV};
  // settings are stored as written; only reserved bits drop
  sew_wr_t cl[6] = '{'{`SEW_A_CTRL, 32'hfffffff0, 32'h70}, '{`SEW_A_WSIZE, 32'he0010145, 32'h00010145},
    '{`SEW_A_WOFS, 32'hffffffff, 32'h1fff1fff}, '{`SEW_A_PDIV, 32'hffffff03, 32'h00000003},
    '{`SEW_A_FTIME, 32'hffffffff, 32'h000fffff}, '{`SEW_A_EXPO, 32'hffffffff, 32'h00ffffff}};

  sew_readout uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .trig_pin(trig_pin), .sens_reset_all(sens_reset_all),
    .sens_transfer(sens_transfer), .sens_rd(sens_rd), .sens_row(sens_row), .sens_col(sens_col),
    .sens_data(sens_data), .out_valid(out_valid), .out_pix(out_pix));
  sew_sensor_model sensor (.aclk(aclk), .sens_rd(sens_rd), .sens_row(sens_row), .sens_col(sens_col),
    .sens_data(sens_data));

  initial begin
    forever #5 aclk = ~aclk;
  end

  function automatic logic [9:0] px(int r, int c);
    return 10'(r * 37 + c * 3);
  endfunction

  function automatic logic [10:0] ex(logic [6:0] ct, int ho, int vo, int wo, int k);
    int r, c;
    logic [11:0] s;
    r = k / wo;
    c = k % wo;
    if (ct[5]) begin
      s = 12'(px(vo + 2 * r, ho + 2 * c)) + 12'(px(vo + 2 * r, ho + 2 * c + 1))
        + 12'(px(vo + 2 * r + 1, ho + 2 * c)) + 12'(px(vo + 2 * r + 1, ho + 2 * c + 1));
      return {c == wo - 1, s[11:2]};
    end
    if (ct[6]) return {c == wo - 1, px(vo + 2 * r, ho + 2 * c)};
    return {c == wo - 1, px(vo + r, ho + c)};
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic axw(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // frame statistics, cleared by the main sequence at a falling edge
  always @(posedge aclk) begin
    cyc++;
    if (sens_transfer) begin
      if (n_rst != 1) r1bad = 1'b1;
      n_rst = 0;
      if (n_xfer == 0) expo_m = cyc - t_rst;
      if (n_xfer > 0) per_m = cyc - t_xfer;
      t_xfer = cyc;
      n_xfer++;
      t_rd = 0;
      reading = 1'b1;
    end
    if (sens_reset_all) begin
      n_rst++;
      t_rst = cyc;
      if (reading) ovl = 1'b1;
    end
    if (sens_rd && reading) begin
      if (t_rd != 0 && cyc - t_rd < gmin) gmin = cyc - t_rd;
      if (t_rd != 0 && cyc - t_rd > gmax) gmax = cyc - t_rd;
      t_rd = cyc;
    end
    if (out_valid && arm && out_pix.sof) begin
      arm = 1'b0;
      cap = 1'b1;
    end
    if (out_valid && cap) begin
      q.push_back({out_pix.eol, out_pix.data});
      if (q.size() == nexp) begin
        cap = 1'b0;
        done = 1'b1;
        reading = 1'b0;
      end
    end
  end

  task automatic run_row(sew_row_t t);
    int e, w, h, k;
    logic [1:0] rs;
    logic [31:0] st;
    axw(`SEW_A_CTRL, 32'h0, rs);
    // a frame in flight from the last set-up must drain first
    st = 32'h1;
    for (k = 0; k < 4000 && st[3:0] != 4'h0; k++) axr(`SEW_A_STAT, st, rs);
    chk("idle before set-up", st[3:0], 0);
    axw(`SEW_A_EXPO, 32'(t.expo), rs);
    axw(`SEW_A_FTIME, 32'(t.ftime), rs);
    axw(`SEW_A_WOFS, t.wofs, rs);
    axw(`SEW_A_WSIZE, t.wsize, rs);
    axw(`SEW_A_PDIV, 32'(t.pdiv), rs);
    w = (t.wsize[12:0] < `SEW_MIN_W) ? `SEW_MIN_W : t.wsize[12:0] / `SEW_W_STEP * `SEW_W_STEP;
    h = (t.wsize[28:16] < `SEW_MIN_H) ? `SEW_MIN_H : t.wsize[28:16];
    if (t.ctrl[5] || t.ctrl[6]) {w, h} = {w / 2, h / 2};
    e = (t.expo < `SEW_EXP_MIN_US) ? `SEW_EXP_MIN_US : t.expo;
    @(negedge aclk);
    {arm, cap, done, reading, ovl, r1bad} = 6'h20;
    {n_rst, n_xfer, t_rd, gmax, gmin, nexp} = {32'h0, 32'h0, 32'h0, 32'h0, 32'hfffff, 32'(w * h)};
    q.delete();
    axw(`SEW_A_CTRL, 32'(t.ctrl), rs);
    if (t.ctrl[1]) begin
      trig_pin <= 1'b1;
      repeat (t.ctrl[2] ? e * 100 : 10) @(posedge aclk);
      trig_pin <= 1'b0;
    end
    for (k = 0; k < 30000 && !(done && (!t.ctrl[3] || n_xfer > 1)); k++) @(posedge aclk);
    chk("frame done", 32'(done), 1);
    for (k = 0; k < q.size(); k++) begin
      chk("pixel", 32'(q[k]), 32'(ex(t.ctrl, t.wofs[12:0], t.wofs[28:16], w, k)));
    end
    chk("exposure", 32'(expo_m >= e * 100 - 5 && expo_m <= e * 100 + 110), 1);
    chk("order", 32'(r1bad), 0);
    chk("overlap", 32'(ovl), 32'(!t.ctrl[1]));
    chk("pixel gap", gmin, 32'(t.pdiv) + 1);
    chk("row blank", 32'(gmax >= `SEW_ROW_BLANK_CYC), 32'(!(t.ctrl[4] && !t.ctrl[5])));
    if (t.ctrl[3]) chk("period", 32'(per_m >= t.ftime * 100 && per_m <= t.ftime * 100 + 110), 1);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) run_row(rows[i]);
    // second reset in mid-run, then registers
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("idle outputs", 32'({sens_rd, sens_transfer, out_valid, bvalid, rvalid}), 0);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axr(8'(4 * i), d, rs);
      chk("reset value", d, rv[i]);
    end
    axr(8'h1c, d, rs);
    chk("unmapped read", {rs, d[29:0]}, 32'h80000000);
    axw(8'h1c, 32'hffffffff, rs);
    chk("unmapped write", 32'(rs), 2);
    for (int i = 0; i < 6; i++) begin
      axw(cl[i].a, cl[i].w, rs);
      axr(cl[i].a, d, rs);
      chk("stored value", d, cl[i].e);
    end
    end_sim();
  end

  initial begin
    repeat (95000) @(posedge aclk);
    errors++;
    end_sim();
  end
endmodule
